//--- inc/bobe_pkg.sv
// shared constants and types for the byte-op and branch executor
package bobe_pkg;
  localparam int unsigned BOBE_IW = 14;
  localparam int unsigned BOBE_PCW = 15;
  localparam int unsigned BOBE_FAW = 7;
  localparam int unsigned BOBE_DW = 8;
  localparam int unsigned BOBE_KW = 11;
  localparam int unsigned BOBE_LATW = 7;

  // instruction word and pc latch field positions
  localparam int unsigned BOBE_DIR_BIT = 7;
  localparam int unsigned BOBE_LAT_LO = 3;
  localparam int unsigned BOBE_LAT_HI = 6;

  // opcode patterns and the masks that select their fixed bits
  localparam logic [13:0] BOBE_MASK_BYTE = 14'h3F00;
  localparam logic [13:0] BOBE_MASK_CLR = 14'h3FFC;
  localparam logic [13:0] BOBE_MASK_JUMP = 14'h3800;
  localparam logic [13:0] BOBE_OPC_DEC = 14'h0300;
  localparam logic [13:0] BOBE_OPC_CLR = 14'h0100;
  localparam logic [13:0] BOBE_OPC_DECSZ = 14'h0B00;
  localparam logic [13:0] BOBE_OPC_INCSZ = 14'h0F00;
  localparam logic [13:0] BOBE_OPC_JUMP = 14'h2800;
  localparam logic [13:0] BOBE_OPC_IOR = 14'h3800;
  localparam logic [13:0] BOBE_OPC_NONE = 14'h0000;

  // values after reset, and the constant one used to step
  localparam logic [7:0] BOBE_W_RST = 8'h00;
  localparam logic BOBE_Z_RST = 1'h0;
  localparam logic [14:0] BOBE_PC_RST = 15'h0000;
  localparam logic [6:0] BOBE_FA_RST = 7'h00;
  localparam logic [7:0] BOBE_ONE = 8'h01;

  typedef enum logic [2:0] {
    BOBE_OP_NONE,
    BOBE_OP_DEC,
    BOBE_OP_CLR,
    BOBE_OP_DECSZ,
    BOBE_OP_INCSZ,
    BOBE_OP_JUMP,
    BOBE_OP_IOR
  } bobe_op_t;

  typedef enum {
    BOBE_ST_EXEC,
    BOBE_ST_FLUSH
  } bobe_state_t;
endpackage

//--- inc/bobe_if.sv
// carrier between the executor control and its result unit
`timescale 1ns/1ps
interface bobe_if;
  import bobe_pkg::*;
  bobe_op_t op;
  logic [7:0] fdata;
  logic [7:0] wval;
  logic [7:0] lit;
  logic [7:0] result;
  logic zero;
  modport ctrl (output op, output fdata, output wval, output lit, input result, input zero);
  modport alu (input op, input fdata, input wval, input lit, output result, output zero);
endinterface

//--- design/bobe_alu.sv
// result unit: computes the 8-bit result and its zero test
`timescale 1ns/1ps
module bobe_alu
  import bobe_pkg::*;
(
  bobe_if.alu bus
);
  logic [7:0] res;

  always_comb begin
    case (bus.op)
      BOBE_OP_DEC: res = bus.fdata - BOBE_ONE;
      BOBE_OP_DECSZ: res = bus.fdata - BOBE_ONE;
      BOBE_OP_INCSZ: res = bus.fdata + BOBE_ONE;
      BOBE_OP_CLR: res = BOBE_W_RST;
      BOBE_OP_IOR: res = bus.wval | bus.lit;
      default: res = bus.wval;
    endcase
  end

  assign bus.result = res;
  assign bus.zero = (res == 8'h00);
endmodule

//--- design/bobe_top.sv
// byte-op and branch executor: six instructions, skip and branch flush
// What this block does
// - decrement_file subtracts one from f, routes by direction bit, updates zero.
// - clear_working zeroes the working register and sets zero; no operands.
// - decrement_skip_zero subtracts one, routes by direction bit, flags untouched.
// - zero decrement result turns the next instruction into no_operation.
// - increment_skip_zero adds one, routes by direction bit, flags untouched.
// - zero increment result turns the next instruction into no_operation.
// - jump_absolute loads k into pc 10:0 and latch bits 6:3 into pc 14:11.
// - jump_absolute takes two cycles and leaves every flag unchanged.
// - or_literal_working ORs an 8-bit literal into working, updates zero.
`timescale 1ns/1ps
module bobe_top
  import bobe_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic instr_valid,
  input wire logic [BOBE_IW-1:0] instr,
  input wire logic [BOBE_DW-1:0] file_rdata,
  input wire logic [BOBE_LATW-1:0] pc_upper_latch,
  output logic [BOBE_FAW-1:0] file_addr,
  output logic [BOBE_DW-1:0] file_wdata,
  output logic file_we,
  output logic [BOBE_DW-1:0] w_reg,
  output logic zero_flag,
  output logic [BOBE_PCW-1:0] pc,
  output logic pc_load,
  output logic noop_cycle
);
  bobe_if bus ();

  bobe_alu u_alu (
    .bus(bus)
  );

  // decode
  wire logic hit_dec = (instr & BOBE_MASK_BYTE) == BOBE_OPC_DEC;
  wire logic hit_clr = (instr & BOBE_MASK_CLR) == BOBE_OPC_CLR;
  wire logic hit_decsz = (instr & BOBE_MASK_BYTE) == BOBE_OPC_DECSZ;
  wire logic hit_incsz = (instr & BOBE_MASK_BYTE) == BOBE_OPC_INCSZ;
  wire logic hit_jump = (instr & BOBE_MASK_JUMP) == BOBE_OPC_JUMP;
  wire logic hit_ior = (instr & BOBE_MASK_BYTE) == BOBE_OPC_IOR;

  wire bobe_op_t op = hit_dec ? BOBE_OP_DEC :
                      hit_clr ? BOBE_OP_CLR :
                      hit_decsz ? BOBE_OP_DECSZ :
                      hit_incsz ? BOBE_OP_INCSZ :
                      hit_jump ? BOBE_OP_JUMP :
                      hit_ior ? BOBE_OP_IOR : BOBE_OP_NONE;

  // operand fields
  wire logic dir = instr[BOBE_DIR_BIT];
  wire logic [BOBE_FAW-1:0] faddr = instr[BOBE_FAW-1:0];
  wire logic [BOBE_DW-1:0] lit8 = instr[BOBE_DW-1:0];
  wire logic [BOBE_KW-1:0] k11 = instr[BOBE_KW-1:0];
  wire logic [3:0] lat_hi = pc_upper_latch[BOBE_LAT_HI:BOBE_LAT_LO];

  bobe_state_t state_r;
  bobe_state_t state_nxt;
  logic [BOBE_DW-1:0] w_r;
  logic [BOBE_DW-1:0] w_nxt;
  logic z_r;
  logic z_nxt;
  logic [BOBE_PCW-1:0] pc_r;
  logic [BOBE_PCW-1:0] pc_nxt;
  logic [BOBE_FAW-1:0] fa_r;
  logic [BOBE_DW-1:0] fd_r;
  logic fwe_r;
  logic pcl_r;
  logic nop_r;

  assign bus.op = op;
  assign bus.fdata = file_rdata;
  assign bus.wval = w_r;
  assign bus.lit = lit8;

  // an instruction slot after a skip or a branch is consumed as no_operation
  wire logic exec_en = instr_valid && (state_r == BOBE_ST_EXEC);
  wire logic flush_slot = instr_valid && (state_r == BOBE_ST_FLUSH);

  wire logic is_fop = (op == BOBE_OP_DEC) || (op == BOBE_OP_DECSZ) || (op == BOBE_OP_INCSZ);
  wire logic is_skipop = (op == BOBE_OP_DECSZ) || (op == BOBE_OP_INCSZ);
  wire logic do_skip = exec_en && is_skipop && bus.zero;
  wire logic do_jump = exec_en && (op == BOBE_OP_JUMP);

  // results for working register: clear, or-literal, and file ops with dir 0
  wire logic w_wr = exec_en && ((op == BOBE_OP_CLR) || (op == BOBE_OP_IOR) ||
                                (is_fop && !dir));
  wire logic f_wr = exec_en && is_fop && dir;
  // skip ops and the branch keep the flag as it was
  wire logic z_wr = exec_en && ((op == BOBE_OP_DEC) || (op == BOBE_OP_CLR) ||
                                (op == BOBE_OP_IOR));

  assign w_nxt = w_wr ? bus.result : w_r;
  assign z_nxt = z_wr ? bus.zero : z_r;
  // latch bits 6:3 fill pc 14:11 exactly; latch bits 2:0 play no part
  assign pc_nxt = do_jump ? {lat_hi, k11} :
                  instr_valid ? BOBE_PCW'(pc_r + 15'h0001) : pc_r;

  always_comb begin
    case (state_r)
      BOBE_ST_EXEC: state_nxt = (do_skip || do_jump) ? BOBE_ST_FLUSH : BOBE_ST_EXEC;
      BOBE_ST_FLUSH: state_nxt = instr_valid ? BOBE_ST_EXEC : BOBE_ST_FLUSH;
      default: state_nxt = BOBE_ST_EXEC;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_r <= BOBE_ST_EXEC;
      w_r <= BOBE_W_RST;
      z_r <= BOBE_Z_RST;
      pc_r <= BOBE_PC_RST;
    end else begin
      state_r <= state_nxt;
      w_r <= w_nxt;
      z_r <= z_nxt;
      pc_r <= pc_nxt;
    end
  end

  // file write port holds the last address and data; the strobe is one cycle
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      fa_r <= BOBE_FA_RST;
      fd_r <= BOBE_W_RST;
      fwe_r <= 1'h0;
      pcl_r <= 1'h0;
      nop_r <= 1'h0;
    end else begin
      fa_r <= f_wr ? faddr : fa_r;
      fd_r <= f_wr ? bus.result : fd_r;
      fwe_r <= f_wr;
      pcl_r <= do_jump;
      nop_r <= flush_slot;
    end
  end

  assign file_addr = fa_r;
  assign file_wdata = fd_r;
  assign file_we = fwe_r;
  assign w_reg = w_r;
  assign zero_flag = z_r;
  assign pc = pc_r;
  assign pc_load = pcl_r;
  assign noop_cycle = nop_r;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_dec_zero;
    exec_en && op == BOBE_OP_DECSZ && file_rdata == 8'h01;
  endsequence
  sequence s_inc_zero;
    exec_en && op == BOBE_OP_INCSZ && file_rdata == 8'hFF;
  endsequence
  sequence s_jump;
    exec_en && op == BOBE_OP_JUMP;
  endsequence

  property p_dec_file;
    exec_en && op == BOBE_OP_DEC && dir |=>
      file_we && file_wdata == 8'($past(file_rdata) - 8'h01) && w_reg == $past(w_reg)
      && zero_flag == ($past(file_rdata) == 8'h01);
  endproperty
  a_dec_file: assert property (p_dec_file) else $error("decrement to file wrong");

  property p_dec_w;
    exec_en && op == BOBE_OP_DEC && !dir |=>
      !file_we && w_reg == 8'($past(file_rdata) - 8'h01) && zero_flag == (w_reg == 8'h00);
  endproperty
  a_dec_w: assert property (p_dec_w) else $error("decrement to working wrong");

  property p_clr;
    exec_en && op == BOBE_OP_CLR |=> w_reg == 8'h00 && zero_flag && !file_we;
  endproperty
  a_clr: assert property (p_clr) else $error("clear working wrong");

  property p_decsz_route;
    exec_en && op == BOBE_OP_DECSZ |=> zero_flag == $past(zero_flag) && file_we == $past(dir) &&
      (file_we ? file_wdata : w_reg) == 8'($past(file_rdata) - 8'h01);
  endproperty
  a_decsz_route: assert property (p_decsz_route) else $error("decrement skip route wrong");

  property p_decsz_skip;
    s_dec_zero ##1 instr_valid [*1] |=> noop_cycle && !file_we && pc_load == 1'b0;
  endproperty
  a_decsz_skip: assert property (p_decsz_skip) else $error("skip not taken");

  property p_decsz_noskip;
    exec_en && op == BOBE_OP_DECSZ && file_rdata != 8'h01 ##1 instr_valid |=> !noop_cycle;
  endproperty
  a_decsz_noskip: assert property (p_decsz_noskip) else $error("spurious skip");

  property p_incsz_route;
    exec_en && op == BOBE_OP_INCSZ |=> zero_flag == $past(zero_flag) && file_we == $past(dir) &&
      (file_we ? file_wdata : w_reg) == 8'($past(file_rdata) + 8'h01);
  endproperty
  a_incsz_route: assert property (p_incsz_route) else $error("increment skip route wrong");

  property p_incsz_skip;
    s_inc_zero ##1 instr_valid |=> noop_cycle;
  endproperty
  a_incsz_skip: assert property (p_incsz_skip) else $error("increment skip not taken");

  property p_jump_pc;
    s_jump |=> pc_load && pc == {$past(pc_upper_latch[6:3]), $past(instr[10:0])};
  endproperty
  a_jump_pc: assert property (p_jump_pc) else $error("branch target wrong");

  property p_jump_two;
    s_jump ##1 instr_valid |=> noop_cycle && zero_flag == $past(zero_flag, 2)
      && w_reg == $past(w_reg, 2);
  endproperty
  a_jump_two: assert property (p_jump_two) else $error("branch not two cycles");

  property p_ior;
    exec_en && op == BOBE_OP_IOR |=>
      w_reg == ($past(w_reg) | $past(instr[7:0])) && zero_flag == (w_reg == 8'h00);
  endproperty
  a_ior: assert property (p_ior) else $error("or literal wrong");

  property p_faddr;
    exec_en && is_fop && dir |=> file_addr == $past(instr[6:0]);
  endproperty
  a_faddr: assert property (p_faddr) else $error("file address wrong");
endmodule

//--- test/bobe_top_bench.sv
// self-checking bench for the byte-op and branch executor
`timescale 1ns/1ps
module bobe_top_bench;
  import bobe_pkg::*;
  typedef struct packed {
    logic [13:0] i;
    logic [7:0] fr;
    logic [7:0] w;
    logic z;
    logic we;
    logic [6:0] fa;
    logic [7:0] wd;
  } bobe_row_t;
  // rows run in order: each expected w_reg follows from the rows before it
  localparam bobe_row_t ROWS [12] = '{
    '{14'h38F0, 8'h00, 8'hF0, 1'h0, 1'h0, 7'h00, 8'h00},
    '{14'h3800, 8'h00, 8'hF0, 1'h0, 1'h0, 7'h00, 8'h00},
    '{14'h0100, 8'h00, 8'h00, 1'h1, 1'h0, 7'h00, 8'h00},
    '{14'h3800, 8'h00, 8'h00, 1'h1, 1'h0, 7'h00, 8'h00},
    '{14'h0312, 8'h80, 8'h7F, 1'h0, 1'h0, 7'h00, 8'h00},
    '{14'h03FF, 8'h01, 8'h7F, 1'h1, 1'h1, 7'h7F, 8'h00},
    '{14'h0B85, 8'h03, 8'h7F, 1'h1, 1'h1, 7'h05, 8'h02},
    '{14'h0F33, 8'h41, 8'h42, 1'h1, 1'h0, 7'h00, 8'h00},
    '{14'h0103, 8'h00, 8'h00, 1'h1, 1'h0, 7'h00, 8'h00},
    '{14'h0301, 8'h00, 8'hFF, 1'h0, 1'h0, 7'h00, 8'h00},
    '{14'h0B10, 8'h10, 8'h0F, 1'h0, 1'h0, 7'h00, 8'h00},
    '{14'h0FC0, 8'h7F, 8'h0F, 1'h0, 1'h1, 7'h40, 8'h80}
  };
  logic mclk = 1'h0;
  logic rst_n;
  logic instr_valid;
  logic [13:0] instr;
  logic [7:0] file_rdata;
  logic [6:0] pc_upper_latch;
  logic [6:0] file_addr;
  logic [7:0] file_wdata;
  logic file_we;
  logic [7:0] w_reg;
  logic zero_flag;
  logic [14:0] pc;
  logic pc_load;
  logic noop_cycle;
  logic [14:0] exp_pc;
  int err_count = 0;
  int tests_run = 0;
  int cycles = 0;

  bobe_top u_bobe_top (.mclk(mclk), .rst_n(rst_n), .instr_valid(instr_valid), .instr(instr),
    .file_rdata(file_rdata), .pc_upper_latch(pc_upper_latch), .file_addr(file_addr),
    .file_wdata(file_wdata), .file_we(file_we), .w_reg(w_reg), .zero_flag(zero_flag),
    .pc(pc), .pc_load(pc_load), .noop_cycle(noop_cycle));

  always #4 mclk = ~mclk;

  task automatic end_sim;
    $display("counts: %0d mismatches in %0d comparisons", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // a hang is cut short well past the fifty or so cycles the sequence needs
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 1000) begin
      err_count++;
      $display("FAIL %0t run did not finish in time", $time);
      end_sim();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // inputs change 1 ns after the edge; results are read 1 ns after the taking edge
  task automatic exec(input logic [13:0] i, input logic [7:0] fr);
    instr = i;
    file_rdata = fr;
    instr_valid = 1'h1;
    @(posedge mclk);
    #1;
    exp_pc = exp_pc + 15'h0001;
  endtask

  task automatic idle;
    instr_valid = 1'h0;
    @(posedge mclk);
    #1;
  endtask

  task automatic rst_seq;
    rst_n = 1'h0;
    instr_valid = 1'h0;
    repeat (8) @(posedge mclk);
    #1;
    rst_n = 1'h1;
    exp_pc = 15'h0000;
    chk({w_reg, zero_flag, file_we, pc_load, noop_cycle}, 32'h0);
    chk({pc, file_addr, file_wdata}, 32'h0);
  endtask

  initial begin
    instr = 14'h0000;
    file_rdata = 8'h00;
    pc_upper_latch = 7'h00;
    rst_seq();
    for (int n = 0; n < 12; n++) begin
      chk(pc_load, 1'h0);
      exec(ROWS[n].i, ROWS[n].fr);
      chk(w_reg, ROWS[n].w);
      chk(zero_flag, ROWS[n].z);
      chk(file_we, ROWS[n].we);
      if (ROWS[n].we) begin
        chk({file_addr, file_wdata}, {ROWS[n].fa, ROWS[n].wd});
      end
      chk({pc, noop_cycle}, {exp_pc, 1'h0});
    end
    // zero decrement result with a back-to-back follower
    exec(14'h0B85, 8'h01);
    chk({file_we, file_addr, file_wdata, zero_flag}, {1'h1, 7'h05, 8'h00, 1'h0});
    exec(14'h38FF, 8'h00);
    chk({noop_cycle, w_reg, pc}, {1'h1, 8'h0F, exp_pc});
    exec(14'h3830, 8'h00);
    chk({noop_cycle, w_reg}, {1'h0, 8'h3F});
    // zero increment result; idle slots must keep the flush pending
    exec(14'h0F05, 8'hFF);
    chk({w_reg, zero_flag, file_we}, {8'h00, 1'h0, 1'h0});
    idle();
    idle();
    exec(14'h0100, 8'h00);
    chk({noop_cycle, zero_flag, pc}, {1'h1, 1'h0, exp_pc});
    idle();
    chk(noop_cycle, 1'h0);
    exec(14'h0080, 8'h00);
    chk({w_reg, zero_flag, noop_cycle, pc}, {8'h00, 1'h0, 1'h0, exp_pc});
    // jumps: latch bits 2:0 ignored, follower slot flushed, flags untouched
    exec(14'h0100, 8'h00);
    for (int n = 0; n < 3; n++) begin
      pc_upper_latch = (n == 0) ? 7'h48 : (n == 1) ? 7'h07 : 7'h78;
      exec((n == 0) ? 14'h2ABC : (n == 1) ? 14'h2FFF : 14'h2800, 8'h00);
      exp_pc = (n == 0) ? 15'h4ABC : (n == 1) ? 15'h07FF : 15'h7800;
      chk({pc, pc_load, zero_flag}, {exp_pc, 1'h1, 1'h1});
      exec(14'h2123, 8'h00);
      chk({pc, pc_load, noop_cycle, zero_flag}, {exp_pc, 1'h0, 1'h1, 1'h1});
    end
    rst_seq();
    idle();
    end_sim();
  end
endmodule
